// *** core/pbss_array.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbss_array
  import pbss_pkg::*;
(
  input wire logic clk,
  pbss_core_if.mem bus
);

  // Contents survive reset and sleep; no reset on the store
  logic [WORD_W-1:0] store [0:MEM_WORDS-1];

  always_ff @(posedge clk) begin
    if (bus.we) begin
      for (int k = 0; k < BYTES; k++) begin
        if (bus.be[k]) begin // R10
          store[bus.waddr][k*LANE_W +: LANE_W] <=
            bus.wdata[k*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign bus.rdata = store[bus.raddr];

endmodule // pbss_array
`default_nettype wire

// *** core/pbss_burst.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbss_burst
  import pbss_pkg::*;
(
  input wire logic   clk,
  input wire logic   rstn,
  pbss_core_if.burst bus
);

  pbss_burst_s s_q;
  pbss_burst_s s_d;

  always_comb begin
    s_d = s_q;
    if (bus.load) begin
      s_d.start = bus.start; // R15
      s_d.step  = 2'h0;
    end else if (bus.step) begin
      s_d.step = CNT_W'(s_q.step + 2'h1); // R16
    end
  end

  // Suspend keeps start and step, so the current address is reused
  assign bus.addr_lo = burst_addr(s_d.start, s_d.step, bus.linear); // R17

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= BURST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  AST_LOAD_START: assert property (@(posedge clk) disable iff (!rstn)
    bus.load |-> bus.addr_lo == bus.start) // R15
    else $error("burst counter not loaded from low address bits");

  AST_INTERLEAVE: assert property (@(posedge clk) disable iff (!rstn)
    (bus.load && !bus.linear) ##1 (bus.step && !bus.load && !bus.linear)
    |-> bus.addr_lo == ($past(bus.start) ^ 2'h1)) // R18
    else $error("interleaved second address wrong");

  AST_LINEAR: assert property (@(posedge clk) disable iff (!rstn)
    (bus.load && bus.linear) ##1 (bus.step && !bus.load && bus.linear)
    |-> bus.addr_lo == CNT_W'($past(bus.start) + 2'h1)) // R19
    else $error("linear second address wrong");

  AST_SUSPEND: assert property (@(posedge clk) disable iff (!rstn)
    ##1 (!bus.load && !bus.step && bus.linear == $past(bus.linear))
    |-> bus.addr_lo == $past(bus.addr_lo)) // R17
    else $error("suspended burst moved its address");

endmodule // pbss_burst
`default_nettype wire

// *** core/pbss_top.sv ***
// Function
// (R1) Register every input and every read output
// (R2) Read starts on strobe with chip selected
// (R3) Load address and counter, data next edge
// (R4) Outputs off in first cycle after deselect
// (R5) Deselecting strobe turns outputs off
// (R6) Processor strobe cycle is always a read
// (R7) Processor write completes on following cycle
// (R8) Second cycle write: global or byte selects
// (R9) Global write writes all four bytes
// (R10) Byte write touches selected bytes only
// (R11) Drivers off during any write
// (R12) Master raises output enable before driving
// (R13) Controller strobe write takes one cycle
// (R14) Write indication from global or byte enables
// (R15) Two-bit counter loaded from low address
// (R16) Advance low steps burst, both strobes high
// (R17) Advance high suspends at current address
// (R18) Strap high gives interleaved order
// (R19) Strap low gives linear order
// (R20) Sleep entered and left in short time
// (R21) Access pending at sleep may be lost
// (R22) Master deselects around sleep
// (R23) Select needs first, third low, second high
`timescale 1ns/1ps
`default_nettype none
module pbss_top
  import pbss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              processor_addr_strobe_n,
  input  wire logic              controller_addr_strobe_n,
  input  wire logic              burst_advance_n,
  input  wire logic              global_write_n,
  input  wire logic              byte_write_enable_n,
  input  wire logic [BYTES-1:0]  byte_select_n,
  input  wire logic              chip_enable_first_n,
  input  wire logic              chip_enable_second,
  input  wire logic              chip_enable_third_n,
  input  wire logic              output_enable_n,
  input  wire logic              sleep_request,
  input  wire logic              burst_order,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic [BYTES-1:0]  parity_lines_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic      [BYTES-1:0]  parity_lines_out,
  output logic                   dq_oe,
  output logic                   asleep
);

  ////////////////////////////////////////////////////////////////////////
  // State and sub-blocks

  pbss_top_s         s_q;
  pbss_top_s         s_d;
  pbss_pins_s        p;
  pbss_core_if       core ();
  logic [SYNC_W-1:0] settled;
  logic [BYTES-1:0]  mask;
  logic [WORD_W-1:0] din_word;
  logic              selected;
  logic              processor_addr_strobe_n_eff;
  logic              strobe;
  logic              wr_ind;
  logic              sleeping;
  logic              oe_low;
  logic              new_acc;
  logic              desel;
  logic              cont;
  logic              do_write;
  logic              do_read;
  logic [ADDR_W-1:0] acc_addr;

  pbss_burst u_burst (
    .clk  (clk),
    .rstn (rstn),
    .bus  (core.burst)
  );

  pbss_array u_array (
    .clk (clk),
    .bus (core.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode of the registered pins

  assign p = s_q.pin;

  always_comb begin
    din_word = '0;
    for (int k = 0; k < BYTES; k++) begin
      din_word[k*LANE_W +: LANE_W] = {parity_lines_in[k], dq_in[k*8 +: 8]};
    end
  end

  // A pin change counts only once the last two stages agree
  assign settled  = settle(s_q.sync2, s_q.sync3, s_q.stable);
  assign sleeping = settled[SYNC_SLEEP];
  assign oe_low   = !settled[SYNC_OE];

  assign selected = !p.ce1_n && p.ce2 && !p.ce3_n; // R23
  assign processor_addr_strobe_n_eff = !p.processor_addr_strobe_n_n && !p.ce1_n; // R2
  assign strobe   = processor_addr_strobe_n_eff || !p.controller_addr_strobe_n_n;
  assign mask     = write_mask(p.gw_n, p.bwe_n, p.bsel_n); // R9 R14
  assign wr_ind   = |mask; // R14

  // Chip enables only matter on a strobe: selected loads a new address, otherwise it deselects
  assign new_acc  = !sleeping && strobe && selected; // R2 R23
  assign desel    = !sleeping && strobe && !selected; // R5
  assign cont     = !sleeping && !strobe && s_q.active; // R16 R17

  assign do_write = (new_acc && !processor_addr_strobe_n_eff && wr_ind) // R13
                 || (cont && wr_ind); // R7 R8
  assign do_read  = (new_acc && (processor_addr_strobe_n_eff || !wr_ind)) // R6
                 || (cont && !wr_ind);

  assign acc_addr = new_acc ? {p.addr[ADDR_W-1:CNT_W], core.addr_lo}
                            : {s_q.base_hi, s_q.base_b2, core.addr_lo}; // R3

  assign core.load   = new_acc; // R3 R15
  assign core.step   = cont && !p.adv_n; // R16
  assign core.start  = p.addr[CNT_W-1:0];
  assign core.linear = !settled[SYNC_ORDER]; // R18 R19
  assign core.we     = do_write;
  assign core.be     = mask; // R9 R10
  assign core.waddr  = acc_addr;
  assign core.wdata  = p.data;
  assign core.raddr  = acc_addr;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.pin = '{addr:   addr,
                processor_addr_strobe_n_n: processor_addr_strobe_n,
                controller_addr_strobe_n_n: controller_addr_strobe_n,
                adv_n:  burst_advance_n,
                gw_n:   global_write_n,
                bwe_n:  byte_write_enable_n,
                bsel_n: byte_select_n,
                ce1_n:  chip_enable_first_n,
                ce2:    chip_enable_second,
                ce3_n:  chip_enable_third_n,
                data:   din_word}; // R1
    s_d.sync1  = {burst_order, sleep_request, output_enable_n};
    s_d.sync2  = s_q.sync1;
    s_d.sync3  = s_q.sync2;
    s_d.stable = settled;

    if (new_acc) begin
      s_d.active  = 1'b1;
      s_d.base_hi = p.addr[ADDR_W-1:3];
      s_d.base_b2 = p.addr[2];
    end else if (desel || sleeping) begin
      // A burst cut by sleep is simply dropped
      s_d.active = 1'b0; // R5 R21
    end

    if (do_read) begin
      s_d.dq_out = core.rdata; // R1 R3
    end
    // Idle and deselect stages leave the drivers off, so an access that
    // emerges from deselect shows high impedance until its data arrives
    s_d.dq_oe  = do_read && oe_low; // R3 R4 R5 R11 R20
    s_d.asleep = sleeping; // R20
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    dq_out           = '0;
    parity_lines_out = '0;
    for (int k = 0; k < BYTES; k++) begin
      dq_out[k*8 +: 8]    = s_q.dq_out[k*LANE_W +: 8];
      parity_lines_out[k] = s_q.dq_out[k*LANE_W + 8];
    end
  end

  // Enable follows output enable through the synchroniser, so the
  // master must lift it a few cycles before it drives write data
  assign dq_oe  = s_q.dq_oe; // R12
  assign asleep = s_q.asleep;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_READ_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
    (do_read && oe_low) |=> (dq_oe && s_q.dq_out == $past(core.rdata)))
    else $error("read data not driven after the next edge"); // R3

  AST_WRITE_HIZ: assert property (@(posedge clk) disable iff (!rstn)
    do_write |=> !dq_oe) // R11
    else $error("drivers on during a write");

  AST_DESELECT: assert property (@(posedge clk) disable iff (!rstn)
    desel |=> (!dq_oe && !s_q.active)) // R5
    else $error("deselect left drivers on");

  AST_PROCESSOR_ADDR_STROBE_N_READ: assert property (@(posedge clk) disable iff (!rstn)
    (processor_addr_strobe_n_eff && selected && !sleeping) |-> (!core.we && do_read)) // R6
    else $error("processor strobe cycle wrote");

  AST_CONTROLLER_ADDR_STROBE_N_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    (!sleeping && selected && !p.controller_addr_strobe_n_n && p.processor_addr_strobe_n_n && wr_ind)
    |-> (core.we && core.waddr == p.addr)) // R13
    else $error("controller strobe write missed");

  AST_GLOBAL_ALL: assert property (@(posedge clk) disable iff (!rstn)
    (core.we && !p.gw_n) |-> core.be == 4'hF) // R9
    else $error("global write did not select all bytes");

  AST_BYTE_MASK: assert property (@(posedge clk) disable iff (!rstn)
    (core.we && p.gw_n) |-> (!p.bwe_n && core.be == ~p.bsel_n)) // R10
    else $error("byte write mask wrong");

  AST_SECOND_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    (new_acc && processor_addr_strobe_n_eff) ##1 (cont && wr_ind && p.adv_n)
    |-> (core.we && core.waddr == $past(p.addr))) // R7
    else $error("processor write not done on the second cycle");

  AST_SLEEP: assert property (@(posedge clk) disable iff (!rstn)
    sleeping |-> (!core.we && !core.load) ##1 (asleep && !dq_oe)) // R20
    else $error("activity or drive while asleep");

  ////////////////////////////////////////////////////////////////////////
  // Checks on registers, select, write indication, burst and sleep

  AST_REG_PINS: assert property (@(posedge clk) disable iff (!rstn) // R1
    $past(rstn) |-> s_q.pin.processor_addr_strobe_n_n == $past(processor_addr_strobe_n))
    else $error("strobe not captured in the input register");

  // Output register only moves on a read stage
  AST_OUT_HOLD: assert property (@(posedge clk) disable iff (!rstn) // R1
    (rstn && !do_read) |=> s_q.dq_out == $past(s_q.dq_out))
    else $error("output register changed without a read");

  AST_READ_START: assert property (@(posedge clk) disable iff (!rstn) // R2
    (!sleeping && selected && strobe && p.gw_n && p.bwe_n)
    |-> (core.load && do_read))
    else $error("selected strobe did not start a read");

  AST_PROCESSOR_ADDR_STROBE_N_IGNORED: assert property (@(posedge clk) disable iff (!rstn) // R2
    (!p.processor_addr_strobe_n_n && p.ce1_n && p.controller_addr_strobe_n_n) |-> !core.load)
    else $error("processor strobe taken with first enable high");

  AST_READ_NO_OE: assert property (@(posedge clk) disable iff (!rstn) // R3
    (do_read && !oe_low) |=> !dq_oe)
    else $error("read drove the bus with output enable high");

  // Drivers only come on after a read stage, never straight from idle
  AST_FIRST_HIZ: assert property (@(posedge clk) disable iff (!rstn) // R4
    dq_oe |-> ($past(do_read) && $past(oe_low)))
    else $error("drivers on without a preceding read stage");

  AST_WRIND_ON: assert property (@(posedge clk) disable iff (!rstn) // R14
    (!p.gw_n || (!p.bwe_n && !(&p.bsel_n))) |-> wr_ind)
    else $error("write indication missing");

  AST_WRIND_OFF: assert property (@(posedge clk) disable iff (!rstn) // R14
    (p.gw_n && p.bwe_n) |-> !wr_ind)
    else $error("write indication without write enables");

  AST_STEP: assert property (@(posedge clk) disable iff (!rstn) // R16
    (!sleeping && s_q.active && p.processor_addr_strobe_n_n && p.controller_addr_strobe_n_n && !p.adv_n)
    |-> core.step)
    else $error("advance did not step the burst");

  AST_NO_STEP: assert property (@(posedge clk) disable iff (!rstn) // R17
    p.adv_n |-> !core.step)
    else $error("burst stepped with advance high");

  AST_SLEEP_HIZ: assert property (@(posedge clk) disable iff (!rstn) // R20
    asleep |-> !dq_oe)
    else $error("drivers on while asleep");

  AST_SLEEP_EXIT: assert property (@(posedge clk) disable iff (!rstn) // R20
    (asleep && !sleeping) |=> !asleep)
    else $error("sleep not left after the request dropped");

  // A burst that sleep cuts is not resumed on wake
  AST_SLEEP_DROP: assert property (@(posedge clk) disable iff (!rstn) // R21
    sleeping |=> !s_q.active)
    else $error("burst survived sleep");

  AST_SELECT: assert property (@(posedge clk) disable iff (!rstn) // R23
    core.load |-> (!p.ce1_n && p.ce2 && !p.ce3_n))
    else $error("address loaded while not selected");

  AST_LOAD_WRITE: assert property (@(posedge clk) disable iff (!rstn) // R13
    (core.load && core.we) |-> !processor_addr_strobe_n_eff)
    else $error("write on the load stage of a processor strobe");

endmodule // pbss_top
`default_nettype wire

// *** pkg/pbss_core_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pbss_core_if;
  import pbss_pkg::*;
  logic                    load;
  logic                    step;
  logic [CNT_W-1:0]        start;
  logic                    linear;
  logic [CNT_W-1:0]        addr_lo;
  logic                    we;
  logic [BYTES-1:0]        be;
  logic [ADDR_W-1:0]       waddr;
  logic [WORD_W-1:0]       wdata;
  logic [ADDR_W-1:0]       raddr;
  logic [WORD_W-1:0]       rdata;

  modport ctl   (output load, step, start, linear, we, be, waddr, wdata,
                 raddr, input addr_lo, rdata);
  modport burst (input load, step, start, linear, output addr_lo);
  modport mem   (input we, be, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// *** pkg/pbss_pkg.sv ***
`default_nettype none
package pbss_pkg;

  localparam int ADDR_W    = 21;
  localparam int BYTES     = 4;
  localparam int DATA_W    = 32;
  localparam int LANE_W    = 9;
  localparam int WORD_W    = BYTES * LANE_W;
  localparam int MEM_WORDS = 2097152;
  localparam int CNT_W     = 2;

  // Asynchronous pins through the three-stage synchroniser
  localparam int SYNC_W     = 3;
  localparam int SYNC_OE    = 0;
  localparam int SYNC_SLEEP = 1;
  localparam int SYNC_ORDER = 2;
  // Output enable idle high, sleep idle low, order strap idle high
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h5;

  typedef struct packed {
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] step;
  } pbss_burst_s;

  localparam pbss_burst_s BURST_RST = '{start: 2'h0, step: 2'h0};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              processor_addr_strobe_n_n;
    logic              controller_addr_strobe_n_n;
    logic              adv_n;
    logic              gw_n;
    logic              bwe_n;
    logic [BYTES-1:0]  bsel_n;
    logic              ce1_n;
    logic              ce2;
    logic              ce3_n;
    logic [WORD_W-1:0] data;
  } pbss_pins_s;

  localparam pbss_pins_s PINS_RST = '{
    addr: 21'h0, processor_addr_strobe_n_n: 1'b1, controller_addr_strobe_n_n: 1'b1, adv_n: 1'b1, gw_n: 1'b1,
    bwe_n: 1'b1, bsel_n: 4'hF, ce1_n: 1'b1, ce2: 1'b0, ce3_n: 1'b1,
    data: 36'h0};

  typedef struct packed {
    pbss_pins_s          pin;
    logic [SYNC_W-1:0]   sync1;
    logic [SYNC_W-1:0]   sync2;
    logic [SYNC_W-1:0]   sync3;
    logic [SYNC_W-1:0]   stable;
    logic                active;
    logic [ADDR_W-1:3+0] base_hi;
    logic                base_b2;
    logic [WORD_W-1:0]   dq_out;
    logic                dq_oe;
    logic                asleep;
  } pbss_top_s;

  localparam pbss_top_s TOP_RST = '{
    pin: PINS_RST, sync1: SYNC_RST, sync2: SYNC_RST, sync3: SYNC_RST,
    stable: SYNC_RST, active: 1'b0, base_hi: 18'h0, base_b2: 1'b0,
    dq_out: 36'h0, dq_oe: 1'b0, asleep: 1'b0};

  function automatic logic [CNT_W-1:0] burst_addr(
      input logic [CNT_W-1:0] start, input logic [CNT_W-1:0] step,
      input logic linear);
    burst_addr = linear ? CNT_W'(start + step) : (start ^ step);
  endfunction

  function automatic logic [BYTES-1:0] write_mask(
      input logic gw_n, input logic bwe_n, input logic [BYTES-1:0] bsel_n);
    if (!gw_n) write_mask = 4'hF;
    else if (!bwe_n) write_mask = ~bsel_n;
    else write_mask = 4'h0;
  endfunction

  function automatic logic [SYNC_W-1:0] settle(
      input logic [SYNC_W-1:0] s2, input logic [SYNC_W-1:0] s3,
      input logic [SYNC_W-1:0] prev);
    settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & prev);
  endfunction

endpackage
`default_nettype wire

// *** verification/pbss_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbss_far_end
  import pbss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              oe_n,
  input  wire logic              drive,
  input  wire logic [WORD_W-1:0] wdata,
  input  wire logic              dev_oe,
  input  wire logic [WORD_W-1:0] dev_q,
  output logic      [WORD_W-1:0] bus
);
  logic [2:0]        oe_high_cnt = 3'h0;
  logic [WORD_W-1:0] last        = '0;
  logic              may_drive;

  // Output enable goes through three flops inside the device, so the
  // master waits four cycles of it high before it puts data out
  assign may_drive = drive && oe_n && (oe_high_cnt >= 3'h4);

  always @(posedge clk) begin
    if (!oe_n) begin
      oe_high_cnt <= 3'h0;
    end else if (oe_high_cnt != 3'h7) begin
      oe_high_cnt <= oe_high_cnt + 3'h1;
    end
    last <= bus;
  end

  // A released bus shows the inverse of its last value, not a hold
  always_comb begin
    if (dev_oe) begin
      bus = dev_q;
    end else if (may_drive) begin
      bus = wdata;
    end else begin
      bus = ~last;
    end
  end
endmodule // pbss_far_end
`default_nettype wire

// *** verification/pbss_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbss_top_test
  import pbss_pkg::*;
;
  typedef struct packed {
    logic [1:0]  w;
    logic [3:0]  b;
    logic [35:0] d;
    logic [35:0] e;
  } pbss_row_s;

  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic              pstb_n = 1'b1;
  logic              cstb_n = 1'b1;
  logic              step_n = 1'b1;
  logic              allw_n = 1'b1;
  logic              bytew_n = 1'b1;
  logic [BYTES-1:0]  bsel_n = 4'hF;
  logic [2:0]        sel = 3'h2;
  logic              oe_n = 1'b1;
  logic              sleep = 1'b0;
  logic              order = 1'b1;
  logic              drive = 1'b0;
  logic [WORD_W-1:0] wdata = '0;
  logic [WORD_W-1:0] bus;
  logic [DATA_W-1:0] q;
  logic [BYTES-1:0]  qp;
  logic              q_oe;
  logic              asleep;
  logic [1:0]        lo;
  int                errors = 0;
  int                checked = 0;
  int                cycles = 0;
  pbss_row_s         rows [6] = '{
    '{2'h1, 4'hF, 36'h9_1234_5678, 36'h9_1234_5678},
    '{2'h2, 4'hE, 36'h0_CCCC_CCAB, 36'h8_1234_56AB},
    '{2'h2, 4'h5, 36'hF_EEDD_CCBB, 36'hA_EE34_CCAB},
    '{2'h3, 4'h0, 36'h0_0000_0000, 36'hA_EE34_CCAB},
    '{2'h2, 4'hF, 36'h0_0000_0000, 36'hA_EE34_CCAB},
    '{2'h0, 4'hF, 36'h5_0102_0304, 36'h5_0102_0304}};

  pbss_top uut (
    .clk                      (clk),
    .rstn                     (rstn),
    .addr                     (addr),
    .processor_addr_strobe_n  (pstb_n),
    .controller_addr_strobe_n (cstb_n),
    .burst_advance_n          (step_n),
    .global_write_n           (allw_n),
    .byte_write_enable_n      (bytew_n),
    .byte_select_n            (bsel_n),
    .chip_enable_first_n      (sel[2]),
    .chip_enable_second       (sel[1]),
    .chip_enable_third_n      (sel[0]),
    .output_enable_n          (oe_n),
    .sleep_request            (sleep),
    .burst_order              (order),
    .dq_in                    (bus[31:0]),
    .parity_lines_in          (bus[35:32]),
    .dq_out                   (q),
    .parity_lines_out         (qp),
    .dq_oe                    (q_oe),
    .asleep                   (asleep)
  );

  pbss_far_end master (
    .clk    (clk),
    .oe_n   (oe_n),
    .drive  (drive),
    .wdata  (wdata),
    .dev_oe (q_oe),
    .dev_q  ({qp, q}),
    .bus    (bus)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [35:0] e,
                     input logic [35:0] s);
    checked++;
    if (e !== s) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // Pins change by NBA just after an edge; outputs are read right after
  // the next edge, before the design's own updates of that edge land
  task automatic cyc(input logic p, input logic c, input logic v,
                     input logic [1:0] w, input logic [3:0] b,
                     input logic [ADDR_W-1:0] a);
    pstb_n <= p;
    cstb_n <= c;
    step_n <= v;
    {allw_n, bytew_n} <= w;
    bsel_n <= b;
    addr <= a;
    @(posedge clk);
  endtask

  task automatic idle(input int k);
    repeat (k) cyc(1'b1, 1'b1, 1'b1, 2'h3, 4'hF, addr);
  endtask

  task automatic set_oe(input logic v);
    oe_n <= v;
    idle(5);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [1:0] w,
                    input logic [3:0] b, input logic [35:0] d);
    wdata <= d;
    drive <= 1'b1;
    cyc(1'b1, 1'b0, 1'b1, w, b, a);
    drive <= 1'b0;
    idle(1);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [35:0] e);
    cyc(1'b0, 1'b1, 1'b1, 2'h3, 4'hF, a);
    idle(2);
    chk("dq_oe", 36'h1, {35'h0, q_oe});
    chk("word", e, {qp, q});
  endtask

  initial begin
    repeat (8) @(posedge clk);
    chk("reset", 36'h0, {q_oe, asleep, qp, q});
    rstn <= 1'b1;
    idle(4);
    foreach (rows[i]) begin
      set_oe(1'b1);
      wr(21'h123, rows[i].w, rows[i].b, rows[i].d);
      set_oe(1'b0);
      rdchk(21'h123, rows[i].e);
    end
    set_oe(1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(21'h40 + 21'(i), 2'h1, 4'hF, 36'hA0 | 36'(i));
    end
    for (int o = 1; o >= 0; o--) begin
      order <= o[0];
      set_oe(1'b0);
      cyc(1'b0, 1'b1, 1'b1, 2'h3, 4'hF, 21'h41);
      cyc(1'b1, 1'b1, 1'b0, 2'h3, 4'hF, 21'h0);
      for (int n = 0; n < 4; n++) begin
        cyc(1'b1, 1'b1, 1'b0, 2'h3, 4'hF, 21'h0);
        lo = o[0] ? (2'h1 ^ n[1:0]) : (2'h1 + n[1:0]);
        chk("burst", 36'hA0 | 36'(lo), {qp, q});
      end
    end
    // Processor strobe with first enable high must not reload the address
    cyc(1'b0, 1'b1, 1'b1, 2'h3, 4'hF, 21'h42);
    sel <= 3'h6;
    for (int n = 0; n < 4; n++) begin
      cyc(1'b0, 1'b1, 1'b1, 2'h3, 4'hF, 21'h40);
      if (n > 1) chk("suspend", 36'hA2, {qp, q});
    end
    sel <= 3'h2;
    for (int k = 0; k < 3; k++) begin
      rdchk(21'h42, 36'hA2);
      sel <= (k == 0) ? 3'h6 : ((k == 1) ? 3'h0 : 3'h3);
      cyc(1'b1, 1'b0, 1'b1, 2'h3, 4'hF, 21'h43);
      idle(2);
      chk("deselect", 36'h0, {35'h0, q_oe});
      sel <= 3'h2;
      cyc(1'b0, 1'b1, 1'b1, 2'h3, 4'hF, 21'h43);
      idle(1);
      chk("first", 36'h0, {35'h0, q_oe});
      idle(1);
      chk("second", 36'h1, {35'h0, q_oe});
    end
    set_oe(1'b1);
    wr(21'h50, 2'h1, 4'hF, 36'h3_1111_1111);
    wdata <= 36'hF_FFFF_FFFF;
    drive <= 1'b1;
    cyc(1'b0, 1'b1, 1'b0, 2'h1, 4'hF, 21'h50);
    wdata <= 36'h0_2222_2299;
    cyc(1'b1, 1'b1, 1'b1, 2'h2, 4'hE, 21'h50);
    drive <= 1'b0;
    idle(1);
    set_oe(1'b0);
    rdchk(21'h50, 36'h2_1111_1199);
    sel <= 3'h0;
    cyc(1'b1, 1'b0, 1'b1, 2'h3, 4'hF, 21'h0);
    sleep <= 1'b1;
    // Three synchroniser stages, one decode stage, then the flag shows
    idle(5);
    chk("asleep", 36'h2, {34'h0, asleep, q_oe});
    sleep <= 1'b0;
    idle(5);
    chk("awake", 36'h0, {35'h0, asleep});
    sel <= 3'h2;
    rdchk(21'h50, 36'h2_1111_1199);
    final_report();
  end
endmodule // pbss_top_test
`default_nettype wire
